// ==== logic/rtc_alarm_control.sv ====
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_control
    import rtc_alarm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic soft_rst_i,
    input wire logic [rtc_alarm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [rtc_alarm_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    output logic s_axi_rready_dummy_unused_o,
    input wire logic s_axi_rready_i,
    input wire logic half_tick_i,
    input wire logic second_edge_i,
    input wire logic [rtc_alarm_pkg::CNT_W-1:0] cycles_to_rollover_i,
    input wire logic [rtc_alarm_pkg::FIELD_COUNT-1:0] field_match_i,
    input wire logic alarm_feb29_i,
    input wire logic leap_year_i,
    output logic alarm_pulse_o,
    output logic alarm_event_o,
    output logic irq_o
);

    typedef struct packed {
        logic aw_free;
        logic [ADDR_W-1:0] aw_addr;
        logic w_free;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_free;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic enable;
        logic wrap;
        logic pulse;
        logic prox;
        logic [INTERVAL_W-1:0] interval;
        logic [COUNTER_W-1:0] counter;
        logic [COUNTER_W-1:0] counter_seen;
        logic enable_seen;
        logic event_out;
        logic [STATUS_W-1:0] status;
        logic [STATUS_W-1:0] irq_en;
        logic irq;
    } state_type;

    localparam state_type STATE_RESET = '{
        aw_free: 1'b1,
        aw_addr: '0,
        w_free: 1'b1,
        w_data: '0,
        w_strb: '0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        ar_free: 1'b1,
        rvalid: 1'b0,
        rdata: '0,
        rresp: RESP_OKAY,
        enable: 1'b0,
        wrap: 1'b0,
        pulse: 1'b0,
        prox: 1'b0,
        interval: INTERVAL_RESET,
        counter: COUNTER_ZERO,
        counter_seen: COUNTER_ZERO,
        enable_seen: 1'b0,
        event_out: 1'b0,
        status: '0,
        irq_en: '0,
        irq: 1'b0
    };

    state_type s;
    state_type next_s;
    logic hit;

    alarm_interval_match u_match (
        .interval_i(s.interval),
        .half_tick_i(half_tick_i),
        .second_edge_i(second_edge_i),
        .field_match_i(field_match_i),
        .alarm_feb29_i(alarm_feb29_i),
        .leap_year_i(leap_year_i),
        .hit_o(hit)
    );

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        return (addr == OFS_CONTROL) || (addr == OFS_STATUS) ||
            (addr == OFS_CLEAR) || (addr == OFS_ENABLE);
    endfunction

    // counter step on an alarm event
    function automatic logic [COUNTER_W-1:0] counter_step(
        input logic [COUNTER_W-1:0] cnt,
        input logic wrap
    );
        logic [COUNTER_W-1:0] r;
        r = cnt;
        if (cnt != COUNTER_ZERO) begin
            r = cnt - COUNTER_ONE;
        end else if (wrap) begin
            r = COUNTER_TOP;
        end else begin
            r = COUNTER_ZERO;
        end
        return r;
    endfunction

    // reads see the retimed copies, never the live counter mid-update
    function automatic logic [31:0] read_word(
        input state_type st,
        input logic [ADDR_W-1:0] addr
    );
        logic [31:0] w;
        w = '0;
        if (addr == OFS_CONTROL) begin
            w[BIT_ENABLE] = st.enable_seen;
            w[BIT_WRAP] = st.wrap;
            w[BIT_PIV] = st.pulse;
            w[BIT_PROX] = st.prox;
            w[INTERVAL_LSB +: INTERVAL_W] = st.interval;
            w[COUNTER_LSB +: COUNTER_W] = st.counter_seen;
        end else if (addr == OFS_STATUS) begin
            w[STATUS_W-1:0] = st.status;
        end else if (addr == OFS_ENABLE) begin
            w[STATUS_W-1:0] = st.irq_en;
        end
        return w;
    endfunction

    always_comb begin
        next_s = s;

        // write address and data are taken independently
        if (s_axi_awvalid_i && s.aw_free) begin
            next_s.aw_addr = s_axi_awaddr_i;
            next_s.aw_free = 1'b0;
        end
        if (s_axi_wvalid_i && s.w_free) begin
            next_s.w_data = s_axi_wdata_i;
            next_s.w_strb = s_axi_wstrb_i;
            next_s.w_free = 1'b0;
        end
        if (s.bvalid && s_axi_bready_i) begin
            next_s.bvalid = 1'b0;
            next_s.aw_free = 1'b1;
            next_s.w_free = 1'b1;
        end

        // soft resets spare the alarm register, only power-on clears it
        if (soft_rst_i) begin
            next_s.status = '0;
            next_s.irq_en = '0;
        end

        // write commit once both halves are held
        if (!s.aw_free && !s.w_free && !s.bvalid) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (s.aw_addr == OFS_CONTROL) begin
                if (s.w_strb[LANE_CONTROL]) begin
                    if (!s.enable) begin
                        next_s.pulse = s.w_data[BIT_PIV];
                    end
                    next_s.enable = s.w_data[BIT_ENABLE];
                    next_s.wrap = s.w_data[BIT_WRAP];
                    next_s.interval = s.w_data[INTERVAL_LSB +: INTERVAL_W];
                end
                if (s.w_strb[LANE_COUNTER]) begin
                    next_s.counter = s.w_data[COUNTER_LSB +: COUNTER_W];
                end
            end else if (s.aw_addr == OFS_CLEAR) begin
                if (s.w_strb[LANE_COUNTER]) begin
                    next_s.status = next_s.status & ~s.w_data[STATUS_W-1:0];
                end
            end else if (s.aw_addr == OFS_ENABLE) begin
                if (s.w_strb[LANE_COUNTER]) begin
                    next_s.irq_en = s.w_data[STATUS_W-1:0];
                end
            end
        end

        // read channel: one read in flight, data one cycle after address
        if (s.rvalid && s_axi_rready_i) begin
            next_s.rvalid = 1'b0;
            next_s.ar_free = 1'b1;
        end
        if (s_axi_arvalid_i && s.ar_free) begin
            next_s.rdata = read_word(s, s_axi_araddr_i);
            next_s.rresp = mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
            next_s.rvalid = 1'b1;
            next_s.ar_free = 1'b0;
        end

        // alarm event, applied after any software write of the same cycle
        next_s.event_out = 1'b0;
        if (s.enable && hit) begin
            next_s.event_out = 1'b1;
            next_s.pulse = ~next_s.pulse;
            next_s.status[ST_EVENT] = 1'b1;
            // expiry judged on the count before this step, after any same-cycle write
            if ((next_s.counter == COUNTER_ZERO) &&
                !next_s.wrap) begin
                next_s.enable = 1'b0;
                next_s.status[ST_EXPIRED] = 1'b1;
            end
            next_s.counter = counter_step(next_s.counter, next_s.wrap);
        end

        // flag stays up unless the rollover is safely far away
        next_s.prox = (cycles_to_rollover_i <= PROXIMITY_CYCLES);

        next_s.counter_seen = s.counter;
        next_s.enable_seen = s.enable;
        next_s.irq = |(next_s.status & next_s.irq_en);
    end

    // arst_n_i is the power-on reset
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready_o = s.aw_free;
    assign s_axi_wready_o = s.w_free;
    assign s_axi_bvalid_o = s.bvalid;
    assign s_axi_bresp_o = s.bresp;
    assign s_axi_arready_o = s.ar_free;
    assign s_axi_rvalid_o = s.rvalid;
    assign s_axi_rdata_o = s.rdata;
    assign s_axi_rresp_o = s.rresp;
    assign s_axi_rready_dummy_unused_o = 1'b0;
    assign alarm_pulse_o = s.pulse;
    assign alarm_event_o = s.event_out;
    assign irq_o = s.irq;

endmodule
`default_nettype wire

// ==== inc/rtc_alarm_pkg.sv ====
`default_nettype none
package rtc_alarm_pkg;

    // register byte addresses on the bus
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h0C;

    // alarm_control field positions
    localparam int BIT_ENABLE = 15;
    localparam int BIT_WRAP = 14;
    localparam int BIT_PIV = 13;
    localparam int BIT_PROX = 12;
    localparam int INTERVAL_LSB = 8;
    localparam int INTERVAL_W = 4;
    localparam int COUNTER_LSB = 0;
    localparam int COUNTER_W = 8;
    localparam int LANE_COUNTER = 0;
    localparam int LANE_CONTROL = 1;

    // counter constants and reset values
    localparam logic [COUNTER_W-1:0] COUNTER_ZERO = 8'h00;
    localparam logic [COUNTER_W-1:0] COUNTER_TOP = 8'hFF;
    localparam logic [COUNTER_W-1:0] COUNTER_ONE = 8'h01;
    localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 4'h0;

    // rollover proximity window in clock cycles
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] PROXIMITY_CYCLES = 16'h0020;

    // alarm interval codes
    localparam logic [INTERVAL_W-1:0] INT_HALF_SECOND = 4'h0;
    localparam logic [INTERVAL_W-1:0] INT_SECOND = 4'h1;
    localparam logic [INTERVAL_W-1:0] INT_TEN_SECONDS = 4'h2;
    localparam logic [INTERVAL_W-1:0] INT_MINUTE = 4'h3;
    localparam logic [INTERVAL_W-1:0] INT_TEN_MINUTES = 4'h4;
    localparam logic [INTERVAL_W-1:0] INT_HOUR = 4'h5;
    localparam logic [INTERVAL_W-1:0] INT_DAY = 4'h6;
    localparam logic [INTERVAL_W-1:0] INT_WEEK = 4'h7;
    localparam logic [INTERVAL_W-1:0] INT_MONTH = 4'h8;
    localparam logic [INTERVAL_W-1:0] INT_YEAR = 4'h9;

    // time field compare positions
    localparam int FIELD_COUNT = 8;
    localparam int FM_SEC_ONES = 0;
    localparam int FM_SEC_TENS = 1;
    localparam int FM_MIN_ONES = 2;
    localparam int FM_MIN_TENS = 3;
    localparam int FM_HOUR = 4;
    localparam int FM_WEEKDAY = 5;
    localparam int FM_DAY = 6;
    localparam int FM_MONTH = 7;

    // interrupt status bits
    localparam int STATUS_W = 2;
    localparam int ST_EVENT = 0;
    localparam int ST_EXPIRED = 1;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// ==== logic/alarm_interval_match.sv ====
`timescale 1ns/1ps
`default_nettype none
module alarm_interval_match
    import rtc_alarm_pkg::*;
(
    input wire logic [rtc_alarm_pkg::INTERVAL_W-1:0] interval_i,
    input wire logic half_tick_i,
    input wire logic second_edge_i,
    input wire logic [rtc_alarm_pkg::FIELD_COUNT-1:0] field_match_i,
    input wire logic alarm_feb29_i,
    input wire logic leap_year_i,
    output logic hit_o
);

    // fields that must agree for each interval code
    function automatic logic [FIELD_COUNT-1:0] required_fields(
        input logic [INTERVAL_W-1:0] code
    );
        logic [FIELD_COUNT-1:0] m;
        m = '0;
        unique case (code)
            INT_HALF_SECOND, INT_SECOND: m = '0;
            INT_TEN_SECONDS: m[FM_SEC_ONES] = 1'b1;
            INT_MINUTE: m[FM_SEC_TENS:FM_SEC_ONES] = '1;
            INT_TEN_MINUTES: m[FM_MIN_ONES:FM_SEC_ONES] = '1;
            INT_HOUR: m[FM_MIN_TENS:FM_SEC_ONES] = '1;
            INT_DAY: m[FM_HOUR:FM_SEC_ONES] = '1;
            INT_WEEK: m[FM_WEEKDAY:FM_SEC_ONES] = '1;
            INT_MONTH: begin
                m[FM_HOUR:FM_SEC_ONES] = '1;
                m[FM_DAY] = 1'b1;
            end
            INT_YEAR: begin
                m[FM_HOUR:FM_SEC_ONES] = '1;
                m[FM_MONTH:FM_DAY] = '1;
            end
            default: m = '0;
        endcase
        return m;
    endfunction

    logic [FIELD_COUNT-1:0] need;
    logic legal;
    logic tick_ok;
    logic leap_ok;

    always_comb begin
        need = required_fields(interval_i);
        // reserved codes never fire, so a bad setting stays silent
        legal = (interval_i <= INT_YEAR);
        tick_ok = half_tick_i && ((interval_i == INT_HALF_SECOND) || second_edge_i);
        // a 29 february alarm on a yearly interval waits for a leap year
        leap_ok = !((interval_i == INT_YEAR) && alarm_feb29_i) || leap_year_i;
        hit_o = legal && tick_ok && leap_ok && ((field_match_i & need) == need);
    end

endmodule
`default_nettype wire

// ==== test/rtc_alarm_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_sva (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic half_tick_i,
    input wire logic alarm_pulse_o,
    input wire logic alarm_event_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    pulse_toggle_a: assert property (alarm_event_o |-> alarm_pulse_o != $past(alarm_pulse_o))
        else $error("event without pulse toggle");
    event_after_tick_a: assert property (alarm_event_o |-> $past(half_tick_i))
        else $error("event without half tick");
    event_single_a: assert property (alarm_event_o |=> !alarm_event_o)
        else $error("event longer than one cycle");
    write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
        && $stable(s_axi_bresp_o)) else $error("write response dropped");
    read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o
        && !s_axi_arready_o) else $error("read response late");
    rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
        && $stable(s_axi_rdata_o)) else $error("read data dropped");
    upper_zero_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
endmodule
bind rtc_alarm_control rtc_alarm_sva rtc_alarm_sva_i (.clk_sys_i, .arst_n_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .half_tick_i, .alarm_pulse_o, .alarm_event_o);
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rtc_alarm_pkg::*;
    typedef struct packed {logic en; logic [3:0] code; logic [7:0] fm; logic sec, feb, leap, ev;} row_type;
    logic clk_sys_i, arst_n_i, soft_rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
    logic s_axi_arvalid_i, s_axi_rready_i, half_tick_i, second_edge_i, alarm_feb29_i, leap_year_i;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic alarm_pulse_o, alarm_event_o, irq_o;
    logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, field_match_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r, b;
    logic [15:0] cycles_to_rollover_i;
    logic p;
    int num_errors = 0;
    int checks = 0;
    // enable, interval, field matches, second edge, feb 29, leap, expected event
    // only legal interval codes are ever written
    row_type rows[17] = '{'{0,0,8'h00,0,0,0,0}, '{1,0,8'h00,0,0,0,1}, '{1,1,8'hFF,0,0,0,0},
        '{1,1,8'h00,1,0,0,1}, '{1,2,8'h01,1,0,0,1}, '{1,2,8'h00,1,0,0,0}, '{1,3,8'h03,1,0,0,1},
        '{1,4,8'h07,1,0,0,1}, '{1,5,8'h0F,1,0,0,1}, '{1,6,8'h1F,1,0,0,1}, '{1,7,8'h3F,1,0,0,1},
        '{1,7,8'h1F,1,0,0,0}, '{1,8,8'h5F,1,0,0,1}, '{1,9,8'hDF,1,0,0,1}, '{1,9,8'h5F,1,0,0,0},
        '{1,9,8'hDF,1,1,0,0}, '{1,9,8'hDF,1,1,1,1}};
    rtc_alarm_control rtc_alarm_control_i (.clk_sys_i, .arst_n_i, .soft_rst_i, .s_axi_awaddr_i,
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_dummy_unused_o(), .s_axi_rready_i, .half_tick_i, .second_edge_i,
        .cycles_to_rollover_i, .field_match_i, .alarm_feb29_i, .leap_year_i, .alarm_pulse_o,
        .alarm_event_o, .irq_o);
    initial begin
        clk_sys_i = 0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ad, wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        while (!(ad && wd)) begin
            @(posedge clk_sys_i);
            if (!ad && s_axi_awready_o) begin
                ad = 1;
                s_axi_awvalid_i <= 0;
            end
            if (!wd && s_axi_wready_o) begin
                wd = 1;
                s_axi_wvalid_i <= 0;
            end
        end
        s_axi_bready_i <= 1;
        do @(posedge clk_sys_i); while (!s_axi_bvalid_o);
        b = s_axi_bresp_o;
        s_axi_bready_i <= 0;
    endtask
    // a read finishes in a few cycles, well inside the proximity window
    task automatic rd(input logic [7:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        do @(posedge clk_sys_i); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 0;
        s_axi_rready_i <= 1;
        do @(posedge clk_sys_i); while (!s_axi_rvalid_o);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 0;
    endtask
    // one half tick; returns at the edge that ends the one-cycle event
    task automatic tick(input logic sec);
        @(posedge clk_sys_i);
        half_tick_i <= 1;
        second_edge_i <= sec;
        @(posedge clk_sys_i);
        half_tick_i <= 0;
        second_edge_i <= 0;
        @(posedge clk_sys_i);
    endtask
    task automatic wrap_up();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        wrap_up();
    end
    initial begin
        {arst_n_i, soft_rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
        {s_axi_arvalid_i, s_axi_rready_i, half_tick_i, second_edge_i} = '0;
        {alarm_feb29_i, leap_year_i, s_axi_awaddr_i, s_axi_araddr_i, field_match_i} = '0;
        s_axi_wdata_i = '0;
        cycles_to_rollover_i = 16'h1000;
        repeat (16) @(posedge clk_sys_i);
        arst_n_i <= 1;
        rd(OFS_CONTROL);
        chk(d, 32'h00000000);
        foreach (rows[i]) begin
            field_match_i <= rows[i].fm;
            alarm_feb29_i <= rows[i].feb;
            leap_year_i <= rows[i].leap;
            wr(OFS_CONTROL, {16'h0000, rows[i].en, 3'h4, rows[i].code, 8'h05});
            tick(rows[i].sec);
            chk(alarm_event_o, rows[i].ev);
        end
        field_match_i <= 8'h00;
        wr(OFS_CONTROL, 32'h0000C005);
        chk(b, RESP_OKAY);
        p = alarm_pulse_o;
        tick(0);
        chk(alarm_pulse_o, {~p});
        rd(OFS_CONTROL);
        chk(d[7:0], 8'h04);
        wr(OFS_CONTROL, 32'h0000C000);
        tick(0);
        rd(OFS_CONTROL);
        chk({d[15], d[7:0]}, 9'h1FF);
        wr(OFS_ENABLE, 32'h00000003);
        wr(OFS_CLEAR, 32'h00000003);
        wr(OFS_CONTROL, 32'h00008000);
        tick(0);
        rd(OFS_CONTROL);
        chk({d[15], d[7:0]}, 9'h000);
        chk(irq_o, 1);
        rd(OFS_STATUS);
        chk(d, 32'h00000003);
        tick(0);
        chk(alarm_event_o, 0);
        wr(OFS_CLEAR, 32'h00000003);
        chk(irq_o, 0);
        wr(OFS_ENABLE, 32'h00000000);
        wr(OFS_CONTROL, 32'h0000C005);
        tick(0);
        chk(irq_o, 0);
        wr(OFS_ENABLE, 32'h00000001);
        chk(irq_o, 1);
        // irq enable and status clear, the alarm register must survive
        soft_rst_i <= 1;
        @(posedge clk_sys_i);
        soft_rst_i <= 0;
        @(posedge clk_sys_i);
        chk(irq_o, 0);
        rd(OFS_CONTROL);
        chk({d[15], d[7:0]}, 9'h104);
        wr(OFS_CONTROL, 32'h00000000);
        wr(OFS_CONTROL, 32'hFFFF2000);
        chk(alarm_pulse_o, 1);
        wr(OFS_CONTROL, 32'h0000E005);
        wr(OFS_CONTROL, 32'h0000C005);
        chk(alarm_pulse_o, 1);
        rd(OFS_CONTROL);
        chk({d[31:16], d[13]}, 17'h00001);
        cycles_to_rollover_i <= 16'h0020;
        @(posedge clk_sys_i);
        rd(OFS_CONTROL);
        chk(d[12], 1);
        rd(OFS_CONTROL);
        chk(d[7:0], 8'h05);
        cycles_to_rollover_i <= 16'h0021;
        @(posedge clk_sys_i);
        rd(OFS_CONTROL);
        chk(d[12], 0);
        wr(8'h10, 32'h00000000);
        chk(b, RESP_SLVERR);
        rd(8'h10);
        chk(r, RESP_SLVERR);
        arst_n_i <= 0;
        repeat (2) @(posedge clk_sys_i);
        arst_n_i <= 1;
        rd(OFS_CONTROL);
        chk(d, 32'h00000000);
        wrap_up();
    end
endmodule
`default_nettype wire
